/* hdl/seq_plane_font_crtc_horizontal.sv */
`include "seq_crtc_map.svh"
module seq_plane_font_crtc_horizontal (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic char_en,
   // Host register ports
   input wire seq_crtc_pkg::io_req_t io_req,
   output logic [7:0] io_rdata,
   // Outside state
   input wire logic grp0_protect,
   input wire logic extension_protect,
   input wire logic alt_mode,
   input wire seq_crtc_pkg::htiming_t alt_timing,
   input wire seq_crtc_pkg::vreadback_t vreadback,
   input wire logic [1:0] win_size,
   input wire logic [1:0] read_map,
   // CPU memory access
   input wire logic cpu_wr,
   input wire logic [17:0] cpu_addr,
   output logic [3:0] plane_we,
   output logic [1:0] plane_rd,
   output logic [17:0] mem_addr,
   // Text attribute path
   input wire logic attr_bit3,
   output logic [2:0] font_code,
   output logic [15:0] font_base,
   output logic fg_intense,
   // Horizontal timing
   output logic [7:0] hcount,
   output logic disp_en,
   output logic hblank,
   output logic line_tick
);
   import seq_crtc_pkg::*;

   // ----------------------------------------
   // Register file
   // ----------------------------------------
   logic [2:0] sequencer_index, next_sequencer_index;
   logic [5:0] timing_index, next_timing_index;
   logic [3:0] plane_write_mask, next_plane_write_mask;
   logic [5:0] font_table_select, next_font_table_select;
   logic [2:0] plane_memory_mode, next_plane_memory_mode;
   logic char_counter_hold, next_char_counter_hold;
   logic [7:0] horiz_line_total, next_horiz_line_total;
   logic [7:0] horiz_display_end, next_horiz_display_end;
   logic [7:0] horiz_blank_start, next_horiz_blank_start;
   logic [7:0] horiz_blank_end, next_horiz_blank_end;
   logic [7:0] horiz_sync_end, next_horiz_sync_end;
   logic [7:0] next_io_rdata;
   logic seq_wr, crt_wr, grp0_locked;

   always_comb begin
      next_sequencer_index = sequencer_index;
      next_timing_index = timing_index;
      next_plane_write_mask = plane_write_mask;
      next_font_table_select = font_table_select;
      next_plane_memory_mode = plane_memory_mode;
      next_char_counter_hold = char_counter_hold;
      next_horiz_line_total = horiz_line_total;
      next_horiz_display_end = horiz_display_end;
      next_horiz_blank_start = horiz_blank_start;
      next_horiz_blank_end = horiz_blank_end;
      next_horiz_sync_end = horiz_sync_end;
      next_io_rdata = io_rdata;
      seq_wr = io_req.wr && io_req.port == PORT_SEQ_DATA;
      crt_wr = io_req.wr && io_req.port == PORT_TIMING_DATA;
      grp0_locked = (grp0_protect | extension_protect) &&
         timing_index <= `CRT_IDX_GRP0_LAST;
      if (io_req.wr && io_req.port == PORT_SEQ_INDEX) begin
         next_sequencer_index = io_req.data[2:0];
      end
      if (io_req.wr && io_req.port == PORT_TIMING_INDEX) begin
         next_timing_index = io_req.data[5:0];
      end
      if (seq_wr) begin
         // Any index but 7 releases the hold
         next_char_counter_hold =
            (sequencer_index == `SEQ_IDX_HOLD);
         unique case (sequencer_index)
            `SEQ_IDX_MASK: next_plane_write_mask = io_req.data[3:0];
            `SEQ_IDX_FONT: next_font_table_select = io_req.data[5:0];
            `SEQ_IDX_MODE: next_plane_memory_mode = io_req.data[3:1];
            default: ;
         endcase
      end
      if (crt_wr && !grp0_locked) begin
         unique case (timing_index)
            `CRT_IDX_TOTAL: next_horiz_line_total = io_req.data;
            `CRT_IDX_DEND: next_horiz_display_end = io_req.data;
            `CRT_IDX_BSTART: next_horiz_blank_start = io_req.data;
            `CRT_IDX_BEND: next_horiz_blank_end = io_req.data;
            `CRT_IDX_SEND: next_horiz_sync_end = io_req.data;
            default: ;
         endcase
      end
      if (io_req.rd) begin
         next_io_rdata = 8'h00;
         unique case (io_req.port)
            PORT_SEQ_INDEX: next_io_rdata = {5'h00, sequencer_index};
            PORT_TIMING_INDEX: next_io_rdata = {2'h0, timing_index};
            PORT_SEQ_DATA: begin
               unique case (sequencer_index)
                  `SEQ_IDX_MASK:
                     next_io_rdata = {4'h0, plane_write_mask};
                  `SEQ_IDX_FONT:
                     next_io_rdata = {2'h0, font_table_select};
                  `SEQ_IDX_MODE:
                     next_io_rdata = {4'h0, plane_memory_mode, 1'b0};
                  default: next_io_rdata = 8'h00;
               endcase
            end
            PORT_TIMING_DATA: begin
               unique case (timing_index)
                  `CRT_IDX_TOTAL: next_io_rdata = horiz_line_total;
                  `CRT_IDX_DEND: next_io_rdata = horiz_display_end;
                  `CRT_IDX_BSTART: next_io_rdata = horiz_blank_start;
                  `CRT_IDX_BEND: next_io_rdata = horiz_blank_end;
                  `CRT_IDX_SEND: next_io_rdata = horiz_sync_end;
                  `CRT_IDX_VS_START: next_io_rdata =
                     horiz_blank_end[`BEND_PEN_BIT] ?
                     vreadback.vs_start : vreadback.pen_high;
                  `CRT_IDX_VS_END: next_io_rdata =
                     horiz_blank_end[`BEND_PEN_BIT] ?
                     vreadback.vs_end : vreadback.pen_low;
                  default: next_io_rdata = 8'h00;
               endcase
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         sequencer_index <= `RST_SEQ_IDX;
         timing_index <= `RST_CRT_IDX;
         plane_write_mask <= 4'h0;
         font_table_select <= 6'h00;
         plane_memory_mode <= 3'h0;
         char_counter_hold <= 1'b0;
         horiz_line_total <= `RST_BYTE;
         horiz_display_end <= `RST_BYTE;
         horiz_blank_start <= `RST_BYTE;
         horiz_blank_end <= `RST_BYTE;
         horiz_sync_end <= `RST_BYTE;
         io_rdata <= `RST_BYTE;
      end else begin
         sequencer_index <= next_sequencer_index;
         timing_index <= next_timing_index;
         plane_write_mask <= next_plane_write_mask;
         font_table_select <= next_font_table_select;
         plane_memory_mode <= next_plane_memory_mode;
         char_counter_hold <= next_char_counter_hold;
         horiz_line_total <= next_horiz_line_total;
         horiz_display_end <= next_horiz_display_end;
         horiz_blank_start <= next_horiz_blank_start;
         horiz_blank_end <= next_horiz_blank_end;
         horiz_sync_end <= next_horiz_sync_end;
         io_rdata <= next_io_rdata;
      end
   end

   // ----------------------------------------
   // CPU address to plane mapping
   // ----------------------------------------
   logic ext_mem, odd_even, quad;
   logic [17:0] win_mask, masked_addr;
   logic [3:0] next_plane_we;
   logic [1:0] next_plane_rd;
   logic [17:0] next_mem_addr;

   assign ext_mem = plane_memory_mode[`MODE_EXT_BIT - 1];
   assign odd_even = plane_memory_mode[`MODE_OE_BIT - 1];
   assign quad = plane_memory_mode[`MODE_QUAD_BIT - 1];

   always_comb begin
      unique case (win_size)
         2'h0: win_mask = `WIN_4K;
         2'h1: win_mask = `WIN_16K;
         default: win_mask = `WIN_32K;
      endcase
      masked_addr = ext_mem ? cpu_addr : (cpu_addr & win_mask);
      next_plane_rd = read_map;
      next_mem_addr = masked_addr;
      next_plane_we = 4'h0;
      if (quad) begin
         next_plane_rd = masked_addr[1:0];
         next_mem_addr = {2'h0, masked_addr[17:2]};
         next_plane_we = 4'h1 << masked_addr[1:0];
      end else if (!odd_even) begin
         next_plane_we = masked_addr[0] ? 4'ha : 4'h5;
      end else begin
         next_plane_we = 4'hf;
      end
      next_plane_we = cpu_wr ? (next_plane_we & plane_write_mask)
         : 4'h0;
   end

   // ----------------------------------------
   // Character font selection
   // ----------------------------------------
   logic [2:0] code_a, code_b, next_font_code;
   logic fonts_differ, next_fg_intense;

   always_comb begin
      code_a = {font_table_select[3:2], font_table_select[5]};
      code_b = {font_table_select[1:0], font_table_select[4]};
      if (!ext_mem) begin
         // Only tables 0 and 4 reachable
         code_a = {code_a[2], 2'h0};
         code_b = {code_b[2], 2'h0};
      end
      fonts_differ = ext_mem && (code_a != code_b);
      next_font_code = (fonts_differ && attr_bit3) ? code_a : code_b;
      next_fg_intense = fonts_differ ? 1'b0 : attr_bit3;
   end

   // ----------------------------------------
   // Horizontal character counter
   // ----------------------------------------
   logic [7:0] t_total, t_dend, t_bstart, next_hcount;
   logic [5:0] t_bend;
   logic [1:0] t_skew;
   logic [8:0] line_last;
   logic de_raw, next_de_raw, next_hblank, next_line_tick;
   logic [2:0] de_pipe, next_de_pipe;
   logic next_disp_en;

   always_comb begin
      t_total = horiz_line_total;
      t_dend = horiz_display_end;
      t_bstart = horiz_blank_start;
      t_bend = {horiz_sync_end[`SEND_BEND5_BIT],
         horiz_blank_end[4:0]};
      t_skew = horiz_blank_end[6:5];
      if (alt_mode) begin
         t_total = alt_timing.total;
         t_dend = alt_timing.disp_end;
         t_bstart = alt_timing.blank_start;
         t_bend = alt_timing.blank_end;
         t_skew = alt_timing.skew;
      end
      line_last = {1'b0, t_total} + {1'b0, `LINE_EXTRA} - 9'h001;
      next_hcount = hcount;
      next_de_raw = de_raw;
      next_hblank = hblank;
      next_line_tick = 1'b0;
      next_de_pipe = de_pipe;
      next_disp_en = disp_en;
      if (char_counter_hold) begin
         next_hcount = 8'h00;
         next_de_raw = 1'b0;
      end else if (char_en) begin
         if ({1'b0, hcount} >= line_last) begin
            next_hcount = 8'h00;
            next_de_raw = 1'b1;
         end else begin
            next_hcount = hcount + 8'h01;
         end
         if (hcount == t_dend) begin
            next_de_raw = 1'b0;
            next_line_tick = 1'b1;
         end
         if (hcount == t_bstart) begin
            next_hblank = 1'b1;
         end else if (hcount[5:0] == t_bend) begin
            next_hblank = 1'b0;
         end
      end
      if (char_en) begin
         next_de_pipe = {de_pipe[1:0], de_raw};
         next_disp_en = (t_skew == 2'h0) ? de_raw
            : de_pipe[t_skew - 2'h1];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         plane_we <= 4'h0;
         plane_rd <= 2'h0;
         mem_addr <= 18'h00000;
         font_code <= 3'h0;
         font_base <= 16'h0000;
         fg_intense <= 1'b0;
         hcount <= 8'h00;
         de_raw <= 1'b0;
         de_pipe <= 3'h0;
         disp_en <= 1'b0;
         hblank <= 1'b0;
         line_tick <= 1'b0;
      end else begin
         plane_we <= next_plane_we;
         plane_rd <= next_plane_rd;
         mem_addr <= next_mem_addr;
         font_code <= next_font_code;
         font_base <= {next_font_code, 13'h0000};
         fg_intense <= next_fg_intense;
         hcount <= next_hcount;
         de_raw <= next_de_raw;
         de_pipe <= next_de_pipe;
         disp_en <= next_disp_en;
         hblank <= next_hblank;
         line_tick <= next_line_tick;
      end
   end
endmodule // seq_plane_font_crtc_horizontal

/* inc/seq_crtc_map.svh */
`ifndef SEQ_CRTC_MAP_SVH
`define SEQ_CRTC_MAP_SVH
// ----------------------------------------
// Sequencer data indices
// ----------------------------------------
`define SEQ_IDX_MASK 3'h2
`define SEQ_IDX_FONT 3'h3
`define SEQ_IDX_MODE 3'h4
`define SEQ_IDX_HOLD 3'h7
// ----------------------------------------
// Timing data indices
// ----------------------------------------
`define CRT_IDX_TOTAL 6'h00
`define CRT_IDX_DEND 6'h01
`define CRT_IDX_BSTART 6'h02
`define CRT_IDX_BEND 6'h03
`define CRT_IDX_SEND 6'h05
`define CRT_IDX_GRP0_LAST 6'h07
`define CRT_IDX_VS_START 6'h10
`define CRT_IDX_VS_END 6'h11
// ----------------------------------------
// Field positions
// ----------------------------------------
`define MODE_EXT_BIT 1
`define MODE_OE_BIT 2
`define MODE_QUAD_BIT 3
`define BEND_PEN_BIT 7
`define SEND_BEND5_BIT 7
// ----------------------------------------
// Reset values, timing counts and window masks
// ----------------------------------------
`define RST_BYTE 8'h00
`define RST_SEQ_IDX 3'h0
`define RST_CRT_IDX 6'h00
`define LINE_EXTRA 8'h05
`define WIN_4K 18'h00fff
`define WIN_16K 18'h03fff
`define WIN_32K 18'h07fff
`endif

/* inc/seq_crtc_pkg.sv */
package seq_crtc_pkg;
   typedef enum logic [1:0] {
      PORT_SEQ_INDEX,
      PORT_SEQ_DATA,
      PORT_TIMING_INDEX,
      PORT_TIMING_DATA
   } io_port_t;

   typedef struct packed {
      io_port_t port;
      logic wr;
      logic rd;
      logic [7:0] data;
   } io_req_t;

   typedef struct packed {
      logic [7:0] total;
      logic [7:0] disp_end;
      logic [7:0] blank_start;
      logic [5:0] blank_end;
      logic [1:0] skew;
   } htiming_t;

   typedef struct packed {
      logic [7:0] vs_start;
      logic [7:0] vs_end;
      logic [7:0] pen_high;
      logic [7:0] pen_low;
   } vreadback_t;
endpackage

/* testbench/seq_plane_font_crtc_horizontal_assertions.sv */
module seq_plane_font_crtc_horizontal_assertions
   import seq_crtc_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic char_en,
   // Host and memory
   input wire seq_crtc_pkg::io_req_t io_req,
   input wire logic [7:0] io_rdata,
   input wire logic cpu_wr,
   input wire logic [3:0] plane_we,
   // Font and timing
   input wire logic [2:0] font_code,
   input wire logic [15:0] font_base,
   input wire logic [7:0] hcount,
   input wire logic line_tick
);
   timeunit 1ns;
   timeprecision 1ps;
   // --------
   // Index and hold shadow
   // --------
   logic [2:0] seq_idx;
   logic [2:0] next_seq_idx;
   logic held;
   logic next_held;
   always_comb begin
      next_seq_idx = seq_idx;
      next_held = held;
      if (io_req.wr && io_req.port == PORT_SEQ_INDEX) begin
         next_seq_idx = io_req.data[2:0];
      end
      if (io_req.wr && io_req.port == PORT_SEQ_DATA) begin
         next_held = (seq_idx == 3'h7);
      end
   end
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         seq_idx <= 3'h0;
         held <= 1'b0;
      end else begin
         seq_idx <= next_seq_idx;
         held <= next_held;
      end
   end
   // --------
   // Properties
   // --------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   AST_WE_NEEDS_WR: assert property (
      !$past(cpu_wr) |-> plane_we == 4'h0) else $error("stray plane write");
   AST_FONT_BASE: assert property (
      font_base == {font_code, 13'h0000}) else $error("font base wrong");
   AST_HCOUNT_STEP: assert property (
      $changed(hcount) |-> hcount == 8'h00 || hcount == $past(hcount) + 8'h01)
      else $error("hcount jumped");
   AST_HCOUNT_GATED: assert property (
      !$past(char_en) |-> $stable(hcount) || hcount == 8'h00)
      else $error("hcount moved without char enable");
   AST_HOLD_ZERO: assert property (
      held && $past(held) |-> hcount == 8'h00) else $error("hold ignored");
   AST_HOLD_NO_TICK: assert property (
      held [*3] |-> !line_tick) else $error("line tick while held");
   AST_TICK_PULSE: assert property (
      line_tick |=> !line_tick) else $error("line tick too long");
   AST_RDATA_HOLD: assert property (
      !$past(io_req.rd) |-> $stable(io_rdata)) else $error("read data moved");
   AST_TIDX_RESERVED: assert property (
      io_req.rd && io_req.port == PORT_TIMING_INDEX |=> io_rdata[7:6] == 2'h0)
      else $error("timing index reserved bits set");
   AST_SIDX_RESERVED: assert property (
      io_req.rd && io_req.port == PORT_SEQ_INDEX |=> io_rdata[7:3] == 5'h00)
      else $error("sequencer index reserved bits set");
   AST_FONT_RESERVED: assert property (
      io_req.rd && io_req.port == PORT_SEQ_DATA && seq_idx == 3'h3
      |=> io_rdata[7:6] == 2'h0) else $error("font reserved bits set");
endmodule // seq_plane_font_crtc_horizontal_assertions

bind seq_plane_font_crtc_horizontal
   seq_plane_font_crtc_horizontal_assertions u_assertions (.*);

/* testbench/seq_plane_font_crtc_horizontal_tb.sv */
module seq_plane_font_crtc_horizontal_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import seq_crtc_pkg::*;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic char_en = 1'b1;
   io_req_t io_req = '0;
   logic grp0_protect = 1'b0;
   logic extension_protect = 1'b0;
   logic alt_mode = 1'b0;
   htiming_t alt_timing = '0;
   vreadback_t vreadback = 32'h11223344;
   logic [1:0] win_size = 2'h0;
   logic [1:0] read_map = 2'h1;
   logic cpu_wr = 1'b0;
   logic [17:0] cpu_addr = '0;
   logic attr_bit3 = 1'b0;
   logic [7:0] io_rdata, hcount;
   logic [3:0] plane_we;
   logic [1:0] plane_rd;
   logic [17:0] mem_addr;
   logic [2:0] font_code;
   logic [15:0] font_base;
   logic fg_intense, disp_en, hblank, line_tick;
   int fails = 0;
   int total_checks = 0;
   int len, de, hb, lt, r0, r2;
   always #4 core_clk = ~core_clk;
   seq_plane_font_crtc_horizontal u_seq_plane_font_crtc_horizontal (.*);
   // --------
   // Shared tasks
   // --------
   task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d failures %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic io(io_port_t p, logic w, logic [7:0] d);
      @(negedge core_clk);
      io_req = '{port: p, wr: w, rd: !w, data: d};
      @(negedge core_clk);
      io_req = '0;
      @(negedge core_clk);
   endtask
   task automatic rd_chk(string n, io_port_t p, logic [7:0] e);
      io(p, 1'b0, 8'h00);
      check(n, io_rdata, e);
   endtask
   task automatic seq_set(logic [7:0] i, logic [7:0] d);
      io(PORT_SEQ_INDEX, 1'b1, i);
      io(PORT_SEQ_DATA, 1'b1, d);
   endtask
   task automatic tim_set(logic [7:0] i, logic [7:0] d);
      io(PORT_TIMING_INDEX, 1'b1, i);
      io(PORT_TIMING_DATA, 1'b1, d);
   endtask
   task automatic mem(logic w, logic [17:0] a, logic [3:0] we,
                      logic [17:0] ma, logic [1:0] rp);
      @(negedge core_clk);
      cpu_wr = w;
      cpu_addr = a;
      @(negedge core_clk);
      check("plane_we", plane_we, we);
      check("mem_addr", mem_addr, ma);
      check("plane_rd", plane_rd, rp);
      cpu_wr = 1'b0;
   endtask
   task automatic font(logic a, logic [2:0] c, logic f);
      @(negedge core_clk);
      attr_bit3 = a;
      @(negedge core_clk);
      check("font_code", font_code, c);
      check("font_base", font_base, {c, 13'h0000});
      check("fg_intense", fg_intense, f);
   endtask
   // Measure one line between two counter wraps
   task automatic line(output int n, d, b, t, r);
      logic [7:0] prev;
      logic pde;
      prev = 8'h00;
      n = 0;
      while (!(hcount === 8'h00 && prev !== 8'h00) && n < 600) begin
         prev = hcount;
         @(negedge core_clk);
         n++;
      end
      {n, d, b, t, r} = '0;
      pde = 1'b1;
      do begin
         d += disp_en;
         b += hblank;
         t += line_tick;
         if (disp_en && !pde) r = n;
         pde = disp_en;
         prev = hcount;
         @(negedge core_clk);
         n++;
      end while (!(hcount === 8'h00 && prev !== 8'h00) && n < 600);
   endtask
   // --------
   // Scenarios
   // --------
   task automatic t_regs();
      seq_set(8'hfa, 8'h0f);
      rd_chk("seq_index", PORT_SEQ_INDEX, 8'h02);
      rd_chk("plane_mask", PORT_SEQ_DATA, 8'h0f);
      seq_set(8'h03, 8'hff);
      rd_chk("font_sel", PORT_SEQ_DATA, 8'h3f);
      seq_set(8'h04, 8'hff);
      rd_chk("mem_mode", PORT_SEQ_DATA, 8'h0e);
      io(PORT_TIMING_INDEX, 1'b1, 8'hc5);
      rd_chk("timing_index", PORT_TIMING_INDEX, 8'h05);
      grp0_protect = 1'b1;
      tim_set(8'h00, 8'h77);
      grp0_protect = 1'b0;
      extension_protect = 1'b1;
      tim_set(8'h00, 8'h66);
      rd_chk("total_locked", PORT_TIMING_DATA, 8'h00);
      extension_protect = 1'b0;
      tim_set(8'h00, 8'h55);
      rd_chk("total", PORT_TIMING_DATA, 8'h55);
      tim_set(8'h03, 8'h80);
      io(PORT_TIMING_INDEX, 1'b1, 8'h10);
      rd_chk("vsync_start", PORT_TIMING_DATA, 8'h11);
      tim_set(8'h03, 8'h00);
      io(PORT_TIMING_INDEX, 1'b1, 8'h10);
      rd_chk("pen_high", PORT_TIMING_DATA, 8'h33);
   endtask
   task automatic t_plane();
      mem(1'b1, 18'h00006, 4'h4, 18'h00001, 2'h2);
      mem(1'b0, 18'h00007, 4'h0, 18'h00001, 2'h3);
      seq_set(8'h02, 8'h0b);
      mem(1'b1, 18'h00006, 4'h0, 18'h00001, 2'h2);
      seq_set(8'h04, 8'h02);
      mem(1'b1, 18'h00005, 4'ha, 18'h00005, 2'h1);
      mem(1'b1, 18'h00004, 4'h1, 18'h00004, 2'h1);
      mem(1'b1, 18'h3ffff, 4'ha, 18'h3ffff, 2'h1);
      seq_set(8'h04, 8'h04);
      mem(1'b1, 18'h00004, 4'hb, 18'h00004, 2'h1);
      for (int w = 0; w < 3; w++) begin
         win_size = 2'(w);
         mem(1'b1, 18'h3ffff, 4'hb, 18'h3ffff >> (6 - 2 * w + (w > 1)),
             2'h1);
      end
   endtask
   task automatic t_font();
      seq_set(8'h04, 8'h02);
      seq_set(8'h03, 8'h29);
      font(1'b1, 3'h5, 1'b0);
      font(1'b0, 3'h2, 1'b0);
      seq_set(8'h03, 8'h35);
      font(1'b1, 3'h3, 1'b1);
      font(1'b0, 3'h3, 1'b0);
      seq_set(8'h03, 8'h29);
      seq_set(8'h04, 8'h00);
      font(1'b1, 3'h0, 1'b1);
      font(1'b0, 3'h0, 1'b0);
      seq_set(8'h03, 8'h03);
      font(1'b1, 3'h4, 1'b1);
   endtask
   task automatic t_timing();
      logic [7:0] h;
      tim_set(8'h00, 8'h00);
      tim_set(8'h01, 8'h01);
      tim_set(8'h02, 8'h02);
      tim_set(8'h03, 8'h84);
      tim_set(8'h05, 8'h00);
      line(len, de, hb, lt, r0);
      check("line_len", len, 5);
      check("display_len", de, 2);
      check("blank_len", hb, 2);
      check("ticks", lt, 1);
      tim_set(8'h03, 8'hc4);
      line(len, de, hb, lt, r2);
      check("skew", r2 - r0, 2);
      tim_set(8'h05, 8'h80);
      line(len, de, hb, lt, r2);
      check("blank_bit5", hb, 5);
      alt_timing = '{8'h01, 8'h02, 8'h03, 6'h05, 2'h0};
      alt_mode = 1'b1;
      line(len, de, hb, lt, r2);
      line(len, de, hb, lt, r2);
      check("alt_line", len, 6);
      check("alt_display", de, 3);
      alt_mode = 1'b0;
      char_en = 1'b0;
      @(negedge core_clk);
      h = hcount;
      repeat (3) @(negedge core_clk);
      check("hcount_gated", hcount, h);
      char_en = 1'b1;
   endtask
   task automatic t_hold();
      int nz;
      seq_set(8'h07, 8'h5a);
      nz = 0;
      lt = 0;
      repeat (8) begin
         @(negedge core_clk);
         nz += (hcount !== 8'h00);
         lt += line_tick;
      end
      check("held_count", nz, 0);
      check("held_ticks", lt, 0);
      seq_set(8'h00, 8'h03);
      line(len, de, hb, lt, r2);
      check("released", len, 5);
   endtask
   initial begin
      #200000;
      fails++;
      conclude();
   end
   initial begin
      repeat (12) @(negedge core_clk);
      nrst = 1'b1;
      t_regs();
      t_plane();
      t_font();
      t_timing();
      t_hold();
      conclude();
   end
endmodule // seq_plane_font_crtc_horizontal_tb
